// File: hw/fts_core.sv
// Purpose: Flow-through synchronous memory with late write and bursts.
// Assumes: Synchronous pins come from controller logic on i_mclk.
// Notes: Output enable, snooze and burst order are synchronised first.
//
// Overview of operation
// - Write data is taken from the data pins one edge after the write command.
// - Reads and writes may follow in any order with no idle cycle between them.
// - Write select, lane enables and write address are registered on one edge.
// - Each lane enable gates its own byte; all low writes the whole word.
// - Output enable need never toggle around writes.
// - Any inactive chip select at a load floats the data outputs.
// - Advance high continues the read, write or deselect burst of the last load.
// - During advance, address, selects and read/write are ignored; the counter steps.
// - Clock hold high freezes every operation as though no edge had come, except the output enable, which still follows its pin.
// - The array holds 524,288 words of 32 or 36 bits on a 19-bit address.
// - Read data is valid in the period after the edge that took the read.
// - Burst order low counts linearly with wrap, high counts start xor step.
// - Selects count only on load; selected is first low, second high, third low.
// - A selected load with read/write high reads, with it low writes.
// - Snooze freezes the inputs and floats outputs; contents are kept.
`timescale 1ns/1ns
`include "fts_defs.svh"

module fts_core
    import fts_pkg::*;
#(
    parameter int ADDR_W = `FTS_ADDR_W,
    parameter int DATA_W = `FTS_DATA_W,
    parameter int FIFO_DEPTH = `FTS_FIFO_DEPTH
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_clock_hold_n,
    input wire logic i_advance_or_load_sel,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic i_chip_select_first_n,
    input wire logic i_chip_select_second,
    input wire logic i_chip_select_third_n,
    input wire logic i_rd_wr_n,
    input wire logic [`FTS_LANES-1:0] i_byte_lane_write_n,
    input wire logic i_oe_n,
    input wire logic i_burst_order_sel,
    input wire logic i_snooze_request,
    input wire logic [DATA_W-1:0] i_dq,
    output logic [DATA_W-1:0] o_dq_q,
    output logic o_dq_oe_q,
    output logic o_tap_space_q,
    output logic o_tap_valid_q,
    output logic [DATA_W-1:0] o_tap_data,
    input wire logic i_tap_ready
);
    // Lane width follows the data width: 9 bits at 36, 8 at 32
    localparam int LANE_W = DATA_W / `FTS_LANES;

    // -----------------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------------
    function automatic logic [`FTS_BURST_W-1:0] burst_low(
        input logic [`FTS_BURST_W-1:0] start,
        input logic [`FTS_BURST_W-1:0] step,
        input logic interleave
    );
        burst_low = interleave ? (start ^ step) : (start + step);
    endfunction : burst_low

    function automatic logic [DATA_W-1:0] lane_merge(
        input logic [DATA_W-1:0] old_word,
        input logic [DATA_W-1:0] new_word,
        input logic [`FTS_LANES-1:0] lane_n
    );
        lane_merge = old_word;
        for (int i = 0; i < `FTS_LANES; i++) begin
            if (!lane_n[i]) begin
                lane_merge[i*LANE_W +: LANE_W] = new_word[i*LANE_W +: LANE_W];
            end
        end
    endfunction : lane_merge

    // -----------------------------------------------------------------
    // Asynchronous pins
    // -----------------------------------------------------------------
    // Two flops per pin, so the synchronised copy lags its pin by two edges and the registered enable by three
    logic [2:0] meta_q, meta_d, sync_q, sync_d;
    logic oe_n_s, snooze_s, order_s;

    always_comb begin
        meta_d = {i_burst_order_sel, i_snooze_request, i_oe_n};
        sync_d = meta_q;
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= {`FTS_ORDER_RST, `FTS_SNOOZE_RST, `FTS_OE_N_RST};
            sync_q <= {`FTS_ORDER_RST, `FTS_SNOOZE_RST, `FTS_OE_N_RST};
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign oe_n_s = sync_q[0];
    assign snooze_s = sync_q[1];
    assign order_s = sync_q[2];

    // -----------------------------------------------------------------
    // Command and burst state
    // -----------------------------------------------------------------
    logic [DATA_W-1:0] mem [`FTS_WORDS];
    fts_state_e state_q, state_d;
    logic [ADDR_W-1:0] base_q, base_d, beat_addr;
    logic [`FTS_BURST_W-1:0] step_q, step_d, step_use;
    fts_wr_pend_s pend_q, pend_d;
    logic [DATA_W-1:0] dq_d, rd_word;
    logic oe_d, run, sel, rd_beat, wr_beat, tap_space;

    always_comb begin
        run = !i_clock_hold_n && !snooze_s;
        state_d = state_q;
        base_d = base_q;
        step_d = step_q;
        pend_d = pend_q;
        dq_d = o_dq_q;
        sel = !i_chip_select_first_n && i_chip_select_second && !i_chip_select_third_n;
        if (!i_advance_or_load_sel) begin
            step_use = '0;
            beat_addr = i_addr;
            if (!sel) begin
                state_d = FTS_ST_DESEL;
            end else if (i_rd_wr_n) begin
                state_d = FTS_ST_READ;
            end else begin
                state_d = FTS_ST_WRITE;
            end
            base_d = i_addr;
        end else begin
            // Selects and read/write are not looked at here
            step_use = step_q + 1'b1;
            beat_addr = {base_q[ADDR_W-1:`FTS_BURST_W],
                         burst_low(base_q[`FTS_BURST_W-1:0], step_use, order_s)};
        end
        step_d = step_use;
        // Decode the next state so a burst beat acts like its load
        rd_beat = state_d == FTS_ST_READ;
        wr_beat = state_d == FTS_ST_WRITE;
        // Read of a word still waiting for its late data sees that data
        rd_word = mem[beat_addr];
        if (pend_q.valid && pend_q.addr == beat_addr) begin
            rd_word = lane_merge(rd_word, i_dq, pend_q.lane_n);
        end
        if (rd_beat) begin
            dq_d = rd_word;
        end
        // Every running write beat leaves its address for the next edge
        pend_d.valid = wr_beat;
        pend_d.addr = beat_addr;
        pend_d.lane_n = i_byte_lane_write_n;
        if (!run) begin
            state_d = state_q;
            base_d = base_q;
            step_d = step_q;
            pend_d = pend_q;
            dq_d = o_dq_q;
        end
        // Enable follows the pin each edge, even under clock hold; snooze holds it off
        oe_d = (run ? rd_beat : state_q == FTS_ST_READ) && !oe_n_s && !snooze_s;
    end

    // Frozen edges re-register the old values, so a stall leaves no trace but the enable
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= FTS_ST_DESEL;
            base_q <= '0;
            step_q <= '0;
            pend_q <= '0;
            o_dq_q <= '0;
            o_dq_oe_q <= 1'b0;
        end else begin
            state_q <= state_d;
            base_q <= base_d;
            step_q <= step_d;
            pend_q <= pend_d;
            o_dq_q <= dq_d;
            o_dq_oe_q <= oe_d;
        end
    end

    // -----------------------------------------------------------------
    // Array write, one edge after the command
    // -----------------------------------------------------------------
    // No reset: contents survive a reset, as in a real array
    always_ff @(posedge i_mclk) begin
        if (run && pend_q.valid) begin
            mem[pend_q.addr] <= lane_merge(mem[pend_q.addr], i_dq, pend_q.lane_n);
        end
    end

    // -----------------------------------------------------------------
    // Read tap: a copy of each read word for a side consumer
    // -----------------------------------------------------------------
    // Word is dropped if the tap is full; the array path never stalls.
    // Consumer must keep pace with the read beats to see every word
    fts_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) fts_fifo_i (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_in_valid(run && rd_beat),
        .i_in_data(rd_word),
        .o_in_ready_q(tap_space),
        .o_out_valid_q(o_tap_valid_q),
        .o_out_data(o_tap_data),
        .i_out_ready(i_tap_ready)
    );

    assign o_tap_space_q = tap_space;

endmodule : fts_core

// File: hw/fts_defs.svh
// Purpose: Constants of the flow-through late-write synchronous memory.
// Assumes: One 50 MHz clock; controller logic on the same clock.
// Notes: Address width, data width and tap depth are defaults; the core takes them as parameters.
`ifndef FTS_DEFS_SVH
`define FTS_DEFS_SVH

// ---------------------------------------------------------------------
// Array shape
// ---------------------------------------------------------------------
`define FTS_ADDR_W 19
`define FTS_WORDS 524288
`define FTS_DATA_W 36
`define FTS_LANES 4
`define FTS_BURST_W 2

// ---------------------------------------------------------------------
// Read tap buffer
// ---------------------------------------------------------------------
`define FTS_FIFO_DEPTH 16

// ---------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------
`define FTS_OE_N_RST 1'h1
`define FTS_SNOOZE_RST 1'h0
`define FTS_ORDER_RST 1'h1

`endif

// File: hw/fts_fifo.sv
// Purpose: Synchronous FIFO with valid and ready on both sides.
// Assumes: One clock; DEPTH is a power of two.
// Notes: Ready and valid are registered so the top drives them from flops.
`timescale 1ns/1ns

module fts_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 16
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready_q,
    output logic o_out_valid_q,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
    logic [PW:0] count_q, count_d;
    logic push, pop;

    // -----------------------------------------------------------------
    // Pointers and flags
    // -----------------------------------------------------------------
    always_comb begin
        push = i_in_valid && o_in_ready_q;
        pop = o_out_valid_q && i_out_ready;
        wr_ptr_d = push ? wr_ptr_q + 1'b1 : wr_ptr_q;
        rd_ptr_d = pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
        count_d = count_q;
        if (push && !pop) begin
            count_d = count_q + 1'b1;
        end else if (pop && !push) begin
            count_d = count_q - 1'b1;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
            o_in_ready_q <= 1'b1;
            o_out_valid_q <= 1'b0;
        end else begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            count_q <= count_d;
            o_in_ready_q <= count_d != (PW+1)'(DEPTH);
            o_out_valid_q <= count_d != '0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (push) begin
            mem[wr_ptr_q] <= i_in_data;
        end
    end

    assign o_out_data = mem[rd_ptr_q];

endmodule : fts_fifo

// File: hw/fts_pkg.sv
// Purpose: Types shared by the memory core.
// Assumes: fts_defs.svh gives the widths.
// Notes: Write pending entry carries address and lane enables.
`include "fts_defs.svh"

package fts_pkg;

    // -----------------------------------------------------------------
    // Burst state
    // -----------------------------------------------------------------
    typedef enum logic [2:0] {
        FTS_ST_DESEL = 3'h1,
        FTS_ST_READ = 3'h2,
        FTS_ST_WRITE = 3'h4
    } fts_state_e;

    // -----------------------------------------------------------------
    // Late-write entry
    // -----------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic [`FTS_ADDR_W-1:0] addr;
        logic [`FTS_LANES-1:0] lane_n;
    } fts_wr_pend_s;

endpackage : fts_pkg

// File: verification/flowthrough_late_write_sync_sram_bench.sv
// Purpose: Self-checking bench of the memory core through its tap FIFO.
// Assumes: Snooze unused and tied low.
// Notes: Expected words are queued per read beat and compared as the tap pops.
`timescale 1ns/1ns

module flowthrough_late_write_sync_sram_bench;
    logic i_mclk = 0, i_rst_n = 0, i_clock_hold_n = 0, i_oe_n = 0, i_burst_order_sel = 1;
    logic i_snooze_request = 0, i_tap_ready = 1;
    wire logic i_advance_or_load_sel, i_chip_select_first_n, i_chip_select_second;
    wire logic i_chip_select_third_n, i_rd_wr_n;
    wire logic [18:0] i_addr;
    wire logic [3:0] i_byte_lane_write_n;
    wire logic [35:0] i_dq, pin_dq;
    logic [35:0] o_dq_q, o_tap_data, wd;
    logic o_dq_oe_q, o_tap_space_q, o_tap_valid_q, rmode = 0, wmode = 0, wdue = 0, drop = 0;
    int err_count = 0, check_count = 0, cyc = 0;
    logic [31:0] seed = 32'h4239414E, r;
    logic [35:0] mem [int];
    logic [35:0] exp_q [$];
    logic [18:0] base, wad, a;
    logic [1:0] step;
    logic [3:0] wln;
    logic [2:0] bad [3] = '{3'h6, 3'h0, 3'h3};

    fts_core fts_core_i (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_clock_hold_n(i_clock_hold_n),
        .i_advance_or_load_sel(i_advance_or_load_sel),
        .i_addr(i_addr),
        .i_chip_select_first_n(i_chip_select_first_n),
        .i_chip_select_second(i_chip_select_second),
        .i_chip_select_third_n(i_chip_select_third_n),
        .i_rd_wr_n(i_rd_wr_n),
        .i_byte_lane_write_n(i_byte_lane_write_n),
        .i_oe_n(i_oe_n),
        .i_burst_order_sel(i_burst_order_sel),
        .i_snooze_request(i_snooze_request),
        .i_dq(i_dq),
        .o_dq_q(o_dq_q),
        .o_dq_oe_q(o_dq_oe_q),
        .o_tap_space_q(o_tap_space_q),
        .o_tap_valid_q(o_tap_valid_q),
        .o_tap_data(o_tap_data),
        .i_tap_ready(i_tap_ready)
    );
    fts_ctrl_model fts_ctrl_model_i (.o_adv(i_advance_or_load_sel), .o_addr(i_addr),
        .o_first_n(i_chip_select_first_n), .o_second(i_chip_select_second),
        .o_third_n(i_chip_select_third_n), .o_rd_wr_n(i_rd_wr_n),
        .o_lanes(i_byte_lane_write_n), .o_dq(pin_dq));
    assign i_dq = o_dq_oe_q ? o_dq_q : pin_dq;

    initial begin
        forever #10 i_mclk = ~i_mclk;
    end

    function automatic logic [31:0] rnd();
        repeat (32) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction : rnd

    task automatic chk(input logic [35:0] seen, input logic [35:0] want);
        check_count++;
        if (seen !== want) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : chk

    task automatic conclude();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude

    // One running beat: model the write merge, burst count and read word
    task automatic op(input logic burst_advance, input logic rd, input logic [18:0] ad,
            input logic [2:0] cs, input logic [3:0] ln, input logic [35:0] d);
        logic [18:0] ea;
        if (wdue) begin
            for (int i = 0; i < 4; i++) if (!wln[i]) mem[wad][i*9 +: 9] = wd[i*9 +: 9];
        end
        if (!burst_advance) begin
            rmode = cs == 3'h2 && rd;
            wmode = cs == 3'h2 && !rd;
            base = ad;
            step = 0;
        end else step++;
        ea = {base[18:2], i_burst_order_sel ? base[1:0] ^ step : base[1:0] + step};
        if (rmode && !drop) exp_q.push_back(mem[ea]);
        {wdue, wad, wln, wd} = {wmode, ea, ln, d};
        fts_ctrl_model_i.beat(burst_advance, rd, ad, cs, ln, d);
        @(negedge i_mclk);
    endtask : op

    task automatic idle(input int n);
        repeat (n) op(0, 0, 0, 3'h4, 0, 0);
    endtask : idle

    task automatic burst(input logic rd, input logic [18:0] ad, input int n, input logic part,
            input int h);
        for (int k = 0; k < n; k++) begin
            r = rnd();
            if (k > 0 && h > 0) begin
                i_clock_hold_n = 1;
                repeat (h) @(negedge i_mclk);
                i_clock_hold_n = 0;
            end
            // Advance beats carry junk address and selects that must be ignored
            op(k != 0, k ? r[8] : rd, k ? r[18:0] : ad, k ? r[2:0] : 3'h2,
                part ? r[7:4] : 4'h0, {r[3:0], rnd()});
        end
    endtask : burst

    task automatic drain();
        for (int k = 0; k < 80 && exp_q.size() > 0; k++) begin
            r = rnd();
            i_tap_ready = r[0] | r[1];
            idle(1);
        end
        i_tap_ready = 1;
    endtask : drain

    always @(posedge i_mclk) begin
        if (o_tap_valid_q === 1'b1 && i_tap_ready === 1'b1) begin
            if (exp_q.size() > 0) begin
                chk(o_tap_data, exp_q.pop_front());
            end else begin
                // Unexpected word: report expected count 1 against none queued
                chk(36'h0, 36'h1);
            end
        end
        if (++cyc == 3000) begin
            err_count++;
            conclude();
        end
    end

    initial begin
        repeat (20) @(negedge i_mclk);
        i_rst_n = 1;
        idle(4);
        for (int m = 0; m < 2; m++) begin
            i_burst_order_sel = m[0];
            idle(3);
            a = 19'h101 + 19'(m * 5);
            burst(0, a, 5, 0, 0);
            burst(1, a, 5, 0, 0);
            burst(0, a, 4, 1, 0);
            burst(1, a, 4, 0, 0);
        end
        for (int k = 0; k < 6; k++) begin
            burst(0, 19'h7FFFA + 19'(k), 1, 0, 0);
            burst(1, 19'h7FFFA + 19'(k), 1, 0, 0);
        end
        foreach (bad[i]) begin
            op(0, 1, 19'h101, bad[i], 0, 0);
            op(1, 1, 19'h101, 3'h2, 0, 0);
            chk(36'(o_dq_oe_q), 36'h0);
        end
        burst(0, 19'h300, 4, 0, 2);
        burst(1, 19'h302, 4, 0, 1);
        i_oe_n = 1;
        burst(0, 19'h400, 4, 0, 0);
        burst(1, 19'h400, 4, 0, 0);
        chk(36'(o_dq_oe_q), 36'h0);
        i_oe_n = 0;
        burst(1, 19'h401, 4, 0, 0);
        drain();
        // Let an edge pass so ready is not assigned twice in one step
        idle(1);
        i_tap_ready = 0;
        burst(1, 19'h400, 16, 0, 0);
        idle(1);
        chk(36'(o_tap_space_q), 36'h0);
        drop = 1;
        burst(1, 19'h400, 2, 0, 0);
        drop = 0;
        drain();
        idle(4);
        chk(36'(exp_q.size()), 36'h0);
        conclude();
    end
endmodule : flowthrough_late_write_sync_sram_bench

// File: verification/fts_core_assertions.sv
// Purpose: Port-level checks of the memory core.
// Assumes: Snooze stays low; output enable settles within four cycles.
// Notes: Selected means first low, second high, third low.
`timescale 1ns/1ns

module fts_core_assertions #(
    parameter int DATA_W = 36
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_clock_hold_n,
    input wire logic i_advance_or_load_sel,
    input wire logic i_chip_select_first_n,
    input wire logic i_chip_select_second,
    input wire logic i_chip_select_third_n,
    input wire logic i_rd_wr_n,
    input wire logic i_oe_n,
    input wire logic i_snooze_request,
    input wire logic i_tap_ready,
    input wire logic [DATA_W-1:0] o_dq_q,
    input wire logic o_dq_oe_q,
    input wire logic o_tap_space_q,
    input wire logic o_tap_valid_q,
    input wire logic [DATA_W-1:0] o_tap_data
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    logic run;
    logic sel;
    logic tap_idle;
    assign run = !i_clock_hold_n && !i_snooze_request;
    assign sel = !i_chip_select_first_n && i_chip_select_second && !i_chip_select_third_n;
    assign tap_idle = o_tap_space_q && !o_tap_valid_q;
    sequence s_load; run && !i_advance_or_load_sel; endsequence
    sequence s_adv; run && i_advance_or_load_sel; endsequence
    sequence s_rd; (!i_oe_n)[*4] ##0 s_load ##0 (sel && i_rd_wr_n); endsequence
    AST_DESEL_FLOAT: assert property (s_load ##0 !sel |=> !o_dq_oe_q)
        else $error("deselect load left data pins driven");
    AST_DESEL_BURST: assert property (s_load ##0 !sel ##1 s_adv |=> !o_dq_oe_q)
        else $error("deselect burst drove data pins");
    AST_READ_DRIVE: assert property (s_rd |=> o_dq_oe_q)
        else $error("read load did not drive data pins");
    AST_READ_BURST: assert property (s_rd ##1 (s_adv ##0 !i_oe_n) |=> o_dq_oe_q)
        else $error("read burst beat not driven");
    AST_WRITE_QUIET: assert property (s_load ##0 (sel && !i_rd_wr_n) |=> !o_dq_oe_q)
        else $error("write beat drove data pins");
    AST_OE_OFF: assert property (i_oe_n[*4] |=> !o_dq_oe_q)
        else $error("drivers on with output enable off");
    AST_HOLD_FREEZE: assert property (i_clock_hold_n |=> $stable(o_dq_q))
        else $error("read data moved during hold");
    AST_READ_TAP: assert property (s_load ##0 (sel && i_rd_wr_n && tap_idle) |=>
        o_tap_valid_q && o_tap_data == o_dq_q)
        else $error("read word not in tap");
    AST_TAP_HOLD: assert property (o_tap_valid_q && !i_tap_ready |=>
        o_tap_valid_q && $stable(o_tap_data))
        else $error("tap head lost while stalled");
    AST_FULL_VALID: assert property (!o_tap_space_q |-> o_tap_valid_q)
        else $error("tap full but empty");
endmodule : fts_core_assertions

bind fts_core fts_core_assertions #(.DATA_W(DATA_W)) fts_core_assertions_i (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_clock_hold_n(i_clock_hold_n),
    .i_advance_or_load_sel(i_advance_or_load_sel),
    .i_chip_select_first_n(i_chip_select_first_n),
    .i_chip_select_second(i_chip_select_second),
    .i_chip_select_third_n(i_chip_select_third_n),
    .i_rd_wr_n(i_rd_wr_n),
    .i_oe_n(i_oe_n),
    .i_snooze_request(i_snooze_request),
    .i_tap_ready(i_tap_ready),
    .o_dq_q(o_dq_q),
    .o_dq_oe_q(o_dq_oe_q),
    .o_tap_space_q(o_tap_space_q),
    .o_tap_valid_q(o_tap_valid_q),
    .o_tap_data(o_tap_data)
);

// File: verification/fts_ctrl_model.sv
// Purpose: Memory controller model driving the core's synchronous pins.
// Assumes: One beat call per running cycle, at the falling edge.
// Notes: With no write data due, the data pins show the inverse of the last word.
`timescale 1ns/1ns

module fts_ctrl_model (
    output logic o_adv,
    output logic [18:0] o_addr,
    output logic o_first_n,
    output logic o_second,
    output logic o_third_n,
    output logic o_rd_wr_n,
    output logic [3:0] o_lanes,
    output logic [35:0] o_dq
);
    logic wr_mode = 1'b0;
    logic wr_due = 1'b0;
    logic [35:0] wr_data;
    initial begin
        {o_adv, o_addr, o_rd_wr_n, o_lanes, o_dq} = '0;
        {o_first_n, o_second, o_third_n} = 3'h4;
    end
    task automatic beat(input logic burst_advance, input logic rd, input logic [18:0] a,
            input logic [2:0] cs, input logic [3:0] ln, input logic [35:0] d);
        // Late data rides the cycle after its write beat
        o_dq = wr_due ? wr_data : ~o_dq;
        if (!burst_advance) begin
            wr_mode = cs == 3'h2 && !rd;
        end
        wr_due = wr_mode;
        wr_data = d;
        {o_adv, o_addr, o_rd_wr_n, o_lanes} = {burst_advance, a, rd, ln};
        {o_first_n, o_second, o_third_n} = cs;
    endtask : beat
endmodule : fts_ctrl_model
